// file: rtl/strc_pkg.sv
// Constants for the system tick run control block
package strc_pkg;
	localparam logic [7:0] ASI_THREAD_CONFIG = 8'h4A;
	localparam logic [7:0] ASI_TICK_RUN_CONTROL = 8'h4B;
	localparam logic [7:0] VA_TICK_RUN_CONTROL = 8'h00;
	localparam int TARGET_ID_MSB = 9;
	localparam int TARGET_ID_WIDTH = TARGET_ID_MSB + 1;
	localparam int STOP_BIT = 0;
	localparam logic STOP_RESET = 1'b0;
	localparam logic [63:0] COUNTER_RESET = 64'h0;
	localparam logic [3:0] IRQ_LEVEL = 4'hE;
	localparam int CLK_PERIOD_NS = 50;
	// Tick period; rounded down, never below one cycle
	localparam int TICK_PERIOD_NS = 1000;
	localparam int TICK_CYCLES = (TICK_PERIOD_NS / CLK_PERIOD_NS) < 1 ? 1 :
		(TICK_PERIOD_NS / CLK_PERIOD_NS);
	localparam int COMMIT_CYCLES = 2;
	typedef enum logic [1:0] {
		CMT_IDLE = 2'h0,
		CMT_WAIT = 2'h1
	} strc_cmt_t;
endpackage : strc_pkg

// file: rtl/strc_tick_ctrl.sv
// Shared system tick counters with chip-wide run/halt control
//
// Operation
// - Configuration space 4A reads the thread's target id in bits 9:0; writes ignored.
// - Stop bit 0 of control register in space 4B halts counting; clearing resumes.
// - One chip-wide control register starts or stops all cores' counters together.
// - Halted counters never advance, but a new compare value equal to the held count still posts a match.
// - Equal unmasked compare sets match flag; level 14 interrupt if enabled, level below.
// - While halted, sleeping cores are not woken by the tick.
// - Simultaneous control writes are serialised and applied one at a time.
// - The writing core's counter access is held after its control write until commit and pipeline sync.
`timescale 1ns/100ps
`default_nettype none
module strc_tick_ctrl #(
	parameter int NUM_CORES = 16,
	parameter int TICK_DIV = strc_pkg::TICK_CYCLES,
	parameter int COMMIT_LAT = strc_pkg::COMMIT_CYCLES
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [NUM_CORES-1:0] regReq,
	input wire logic [NUM_CORES-1:0] regWrite,
	input wire logic [NUM_CORES-1:0] regSupervisor,
	input wire logic [NUM_CORES-1:0][7:0] regAsi,
	input wire logic [NUM_CORES-1:0][7:0] regVa,
	input wire logic [NUM_CORES-1:0][63:0] regWdata,
	output logic [NUM_CORES-1:0] regAck_r,
	output logic [NUM_CORES-1:0][63:0] regRdata_r,
	input wire logic [NUM_CORES-1:0] cntReq,
	input wire logic [NUM_CORES-1:0] cntWrite,
	input wire logic [NUM_CORES-1:0][63:0] cntWdata,
	input wire logic [NUM_CORES-1:0] pipeSync,
	output logic [NUM_CORES-1:0] cntAck_r,
	output logic [NUM_CORES-1:0][63:0] cntRdata_r,
	output logic [NUM_CORES-1:0] cntHold_r,
	input wire logic [NUM_CORES-1:0][63:0] systemTickCompare,
	input wire logic [NUM_CORES-1:0] compareIrqMask,
	input wire logic [NUM_CORES-1:0] softintMatchClr,
	input wire logic [NUM_CORES-1:0] interruptEnableBit,
	input wire logic [NUM_CORES-1:0][3:0] processorPriorityLevel,
	input wire logic [NUM_CORES-1:0] coreSleeping,
	output logic [NUM_CORES-1:0] softintMatchFlag_r,
	output logic [NUM_CORES-1:0] irqLevel14_r,
	output logic [NUM_CORES-1:0] wakeCore_r,
	output logic tickStopped_r
);
	localparam int IDXW = NUM_CORES > 1 ? $clog2(NUM_CORES) : 1;
	localparam int DIVW = TICK_DIV > 1 ? $clog2(TICK_DIV) : 1;
	localparam int CMTW = COMMIT_LAT > 1 ? $clog2(COMMIT_LAT) + 1 : 1;
	localparam int TIDW = strc_pkg::TARGET_ID_WIDTH;

	// Register port arbitration and commit of the control register
	logic [IDXW-1:0] rrPtr_r, rrPtr_nxt;
	logic stop_nxt;
	logic pendVal_r, pendVal_nxt;
	logic [CMTW-1:0] cmtCnt_r, cmtCnt_nxt;
	strc_pkg::strc_cmt_t cmtState_r, cmtState_nxt;
	logic [NUM_CORES-1:0] regAck_nxt;
	logic [NUM_CORES-1:0][63:0] regRdata_nxt;
	logic gv, gCfg, gCtlWr;
	logic [IDXW-1:0] gIdx;
	logic [NUM_CORES-1:0] isCtlWr, eligible;

	always_comb begin
		int idx;
		idx = 0;
		gv = 1'b0;
		gIdx = '0;
		for (int i = 0; i < NUM_CORES; i++) begin
			isCtlWr[i] = regWrite[i] && regAsi[i] == strc_pkg::ASI_TICK_RUN_CONTROL &&
				regVa[i] == strc_pkg::VA_TICK_RUN_CONTROL && regSupervisor[i];
			// A second control write waits while one is committing
			eligible[i] = regReq[i] && !regAck_r[i] &&
				!(isCtlWr[i] && cmtState_r != strc_pkg::CMT_IDLE);
		end
		// Round robin so that no core can starve the others
		for (int k = 0; k < NUM_CORES; k++) begin
			idx = (int'(rrPtr_r) + k) % NUM_CORES;
			if (!gv && eligible[idx]) begin
				gv = 1'b1;
				gIdx = IDXW'(idx);
			end
		end
		gCfg = gv && regAsi[gIdx] == strc_pkg::ASI_THREAD_CONFIG && regSupervisor[gIdx];
		gCtlWr = gv && isCtlWr[gIdx];
		rrPtr_nxt = gv ? IDXW'((int'(gIdx) + 1) % NUM_CORES) : rrPtr_r;
		regAck_nxt = '0;
		regRdata_nxt = regRdata_r;
		if (gv) begin
			regAck_nxt[gIdx] = 1'b1;
			regRdata_nxt[gIdx] = '0;
			if (gCfg && !regWrite[gIdx]) begin
				regRdata_nxt[gIdx][strc_pkg::TARGET_ID_MSB:0] = TIDW'(gIdx);
			end else if (regSupervisor[gIdx] &&
				regAsi[gIdx] == strc_pkg::ASI_TICK_RUN_CONTROL &&
				regVa[gIdx] == strc_pkg::VA_TICK_RUN_CONTROL && !regWrite[gIdx]) begin
				// Reads show the committed value, which is how a writer sees commit
				regRdata_nxt[gIdx][strc_pkg::STOP_BIT] = tickStopped_r;
			end
		end
		stop_nxt = tickStopped_r;
		pendVal_nxt = pendVal_r;
		cmtCnt_nxt = cmtCnt_r;
		cmtState_nxt = cmtState_r;
		case (cmtState_r)
			strc_pkg::CMT_IDLE: begin
				if (gCtlWr) begin
					pendVal_nxt = regWdata[gIdx][strc_pkg::STOP_BIT];
					cmtCnt_nxt = CMTW'(COMMIT_LAT - 1);
					cmtState_nxt = strc_pkg::CMT_WAIT;
				end
			end
			strc_pkg::CMT_WAIT: begin
				if (cmtCnt_r == '0) begin
					stop_nxt = pendVal_r;
					cmtState_nxt = strc_pkg::CMT_IDLE;
				end else begin
					cmtCnt_nxt = cmtCnt_r - CMTW'(1);
				end
			end
			default: cmtState_nxt = strc_pkg::CMT_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rrPtr_r <= '0;
			tickStopped_r <= strc_pkg::STOP_RESET;
			pendVal_r <= 1'b0;
			cmtCnt_r <= '0;
			cmtState_r <= strc_pkg::CMT_IDLE;
			regAck_r <= '0;
			regRdata_r <= '0;
		end else begin
			rrPtr_r <= rrPtr_nxt;
			tickStopped_r <= stop_nxt;
			pendVal_r <= pendVal_nxt;
			cmtCnt_r <= cmtCnt_nxt;
			cmtState_r <= cmtState_nxt;
			regAck_r <= regAck_nxt;
			regRdata_r <= regRdata_nxt;
		end
	end

	// Tick prescaler and per-core counters
	logic [DIVW-1:0] div_r, div_nxt;
	logic tickPulse;
	logic [NUM_CORES-1:0][63:0] counter_r, counter_nxt;
	logic [NUM_CORES-1:0] hold_nxt, cntAck_nxt, match;
	logic [NUM_CORES-1:0] flag_nxt, irq_nxt, wake_nxt;
	logic [NUM_CORES-1:0][63:0] cntRdata_nxt;

	always_comb begin
		div_nxt = (int'(div_r) >= TICK_DIV - 1) ? '0 : div_r + DIVW'(1);
		// One shared pulse keeps every core in lockstep
		tickPulse = !tickStopped_r && int'(div_r) >= TICK_DIV - 1;
		for (int i = 0; i < NUM_CORES; i++) begin
			counter_nxt[i] = tickPulse ? counter_r[i] + 64'h1 : counter_r[i];
			// Held from a control write until commit is seen and the core syncs
			hold_nxt[i] = cntHold_r[i];
			if (gCtlWr && gIdx == IDXW'(i)) begin
				hold_nxt[i] = 1'b1;
			end else if (cmtState_r == strc_pkg::CMT_IDLE && pipeSync[i]) begin
				hold_nxt[i] = 1'b0;
			end
			cntAck_nxt[i] = cntReq[i] && !cntHold_r[i] && !cntAck_r[i];
			cntRdata_nxt[i] = cntAck_nxt[i] ? counter_r[i] : cntRdata_r[i];
			if (cntAck_nxt[i] && cntWrite[i]) begin
				counter_nxt[i] = cntWdata[i];
			end
			// Unmasked equality alone decides; a halted counter still matches a compare equal to its value
			match[i] = !compareIrqMask[i] && systemTickCompare[i] == counter_r[i];
			flag_nxt[i] = match[i] || (softintMatchFlag_r[i] && !softintMatchClr[i]);
			irq_nxt[i] = softintMatchFlag_r[i] && interruptEnableBit[i] &&
				processorPriorityLevel[i] < strc_pkg::IRQ_LEVEL;
			wake_nxt[i] = coreSleeping[i] && match[i] && !tickStopped_r;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			div_r <= '0;
			counter_r <= {NUM_CORES{strc_pkg::COUNTER_RESET}};
			cntHold_r <= '0;
			cntAck_r <= '0;
			cntRdata_r <= '0;
			softintMatchFlag_r <= '0;
			irqLevel14_r <= '0;
			wakeCore_r <= '0;
		end else begin
			div_r <= div_nxt;
			counter_r <= counter_nxt;
			cntHold_r <= hold_nxt;
			cntAck_r <= cntAck_nxt;
			cntRdata_r <= cntRdata_nxt;
			softintMatchFlag_r <= flag_nxt;
			irqLevel14_r <= irq_nxt;
			wakeCore_r <= wake_nxt;
		end
	end

	// Helpers read only by the checks below
	logic gCfgRd_r;
	logic [IDXW-1:0] gIdx_r;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			gCfgRd_r <= 1'b0;
			gIdx_r <= '0;
		end else begin
			gCfgRd_r <= gCfg && !regWrite[gIdx];
			gIdx_r <= gIdx;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	sequence ctlWrTaken;
		gCtlWr && cmtState_r == strc_pkg::CMT_IDLE;
	endsequence
	sequence committed;
		cmtState_r == strc_pkg::CMT_IDLE && tickStopped_r == $past(pendVal_r);
	endsequence

	cfg_read_id_a: assert property (gCfgRd_r |-> regAck_r[gIdx_r] &&
		regRdata_r[gIdx_r] == 64'(gIdx_r)) else $error("config read id wrong");
	halt_freeze_a: assert property (tickStopped_r && !cntAck_nxt[0] |=>
		$stable(counter_r[0])) else $error("counter moved while halted");
	lockstep_tick_a: assert property (tickPulse && !cntAck_nxt[0] |=>
		counter_r[0] == $past(counter_r[0]) + 64'h1) else $error("tick step lost");
	serial_write_a: assert property (cmtState_r != strc_pkg::CMT_IDLE |->
		!gCtlWr) else $error("control write overlaps commit");
	commit_bound_a: assert property (ctlWrTaken |-> ##[1:8] committed)
		else $error("control write never committed");
	hold_counter_a: assert property (cntHold_r[0] |=> !cntAck_r[0])
		else $error("counter access during hold");
	match_flag_a: assert property (match[0] |=> softintMatchFlag_r[0])
		else $error("match flag not set");
	irq_level_a: assert property (softintMatchFlag_r[0] && interruptEnableBit[0] &&
		processorPriorityLevel[0] < strc_pkg::IRQ_LEVEL |=> irqLevel14_r[0])
		else $error("irq missed");
	no_wake_halted_a: assert property (tickStopped_r |=> !wakeCore_r[0])
		else $error("core woken while halted");
endmodule : strc_tick_ctrl
`default_nettype wire

// file: verification/strc_core_model.sv
// Processor core model issuing supervisor register requests
`timescale 1ns/100ps
`default_nettype none
module strc_core_model (
	input wire logic clk_sys,
	input wire logic regAck,
	input wire logic [63:0] regRdata,
	output logic regReq,
	output logic regWrite,
	output logic regSupervisor,
	output logic [7:0] regAsi,
	output logic [7:0] regVa,
	output logic [63:0] regWdata
);
	initial begin
		regReq = 1'b0;
		regWrite = 1'b0;
		regSupervisor = 1'b1;
		regAsi = 8'h00;
		regVa = 8'h00;
		regWdata = 64'hA5A5A5A5A5A5A5A5;
	end
	// Called at a falling edge; request held until the ack is sampled high
	task automatic access(input logic w, input logic [7:0] asi, input logic [63:0] d,
		output logic [63:0] q);
		regReq = 1'b1;
		regWrite = w;
		regAsi = asi;
		regWdata = d;
		for (int n = 0; n < 200 && regAck !== 1'b1; n++) @(negedge clk_sys);
		q = regRdata;
		@(negedge clk_sys);
		regReq = 1'b0;
		// Released lines must not look like the last request
		regWrite = ~regWrite;
		regAsi = ~regAsi;
		regWdata = ~regWdata;
		// One idle edge so a following call never re-raises the request in this step
		@(negedge clk_sys);
	endtask : access
	task automatic supervisor(input logic s);
		regSupervisor = s;
	endtask : supervisor
	// Write the stop bit, then read it back until the write is seen committed
	task automatic setStop(input logic v);
		logic [63:0] q;
		access(1'b1, 8'h4B, {63'h0, v}, q);
		q = ~{63'h0, v};
		for (int n = 0; n < 20 && q[0] !== v; n++) access(1'b0, 8'h4B, 64'h0, q);
	endtask : setStop
endmodule : strc_core_model
`default_nettype wire

// file: verification/system_tick_run_control_bench.sv
// Bench for the system tick run control block
`timescale 1ns/100ps
`default_nettype none
module system_tick_run_control_bench;
	localparam int NC = 2;
	localparam int TD = 4;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [NC-1:0] cntReq = '0, pipeSync = '0, mask = '1, intEn = '1, sleep = '1;
	logic [NC-1:0] cntWr = '0, clr = '0;
	logic [NC-1:0][63:0] cmp = '0, cntWd = '0;
	logic [NC-1:0][3:0] prio = {4'hD, 4'hD};
	wire logic [NC-1:0] regReq, regWrite, regSup, regAck, cntAck, cntHold;
	wire logic [NC-1:0] matchFlag, irq, wake;
	wire logic [NC-1:0][7:0] asi, va;
	wire logic [NC-1:0][63:0] wd, rd, crd;
	wire logic stopped;
	int fail_count = 0;
	int checks_done = 0;
	int cyc = 0;
	logic [63:0] a, b, q;
	always #25 clk_sys = ~clk_sys;
	strc_tick_ctrl #(.NUM_CORES(NC), .TICK_DIV(TD), .COMMIT_LAT(2)) i_dut (.clk_sys(clk_sys),
		.reset_n(reset_n), .regReq(regReq), .regWrite(regWrite), .regSupervisor(regSup),
		.regAsi(asi), .regVa(va), .regWdata(wd), .regAck_r(regAck), .regRdata_r(rd),
		.cntReq(cntReq), .cntWrite(cntWr), .cntWdata(cntWd), .pipeSync(pipeSync),
		.cntAck_r(cntAck), .cntRdata_r(crd), .cntHold_r(cntHold), .systemTickCompare(cmp),
		.compareIrqMask(mask), .softintMatchClr(clr), .interruptEnableBit(intEn),
		.processorPriorityLevel(prio), .coreSleeping(sleep), .softintMatchFlag_r(matchFlag),
		.irqLevel14_r(irq),
		.wakeCore_r(wake), .tickStopped_r(stopped));
	for (genvar g = 0; g < NC; g++) begin : g_core
		strc_core_model i_core (.clk_sys(clk_sys), .regAck(regAck[g]), .regRdata(rd[g]),
			.regReq(regReq[g]), .regWrite(regWrite[g]), .regSupervisor(regSup[g]),
			.regAsi(asi[g]), .regVa(va[g]), .regWdata(wd[g]));
	end
	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done
	task automatic cntRead(input int i, output logic [63:0] v);
		cntReq[i] = 1'b1;
		for (int n = 0; n < 100 && cntAck[i] !== 1'b1; n++) @(negedge clk_sys);
		v = crd[i];
		@(negedge clk_sys);
		cntReq[i] = 1'b0;
	endtask : cntRead
	task automatic t_config();
		g_core[1].i_core.access(1'b1, 8'h4A, '1, q);
		g_core[1].i_core.access(1'b0, 8'h4A, 64'h0, q);
		check("thread id", q, 64'h1);
		g_core[1].i_core.supervisor(1'b0);
		g_core[1].i_core.access(1'b0, 8'h4A, 64'h0, q);
		check("user read", q, 64'h0);
		g_core[1].i_core.supervisor(1'b1);
	endtask : t_config
	task automatic t_run();
		fork
			cntRead(0, a);
			cntRead(1, b);
		join
		check("lockstep", b, a);
		repeat (3 * TD - 2) @(negedge clk_sys);
		cntRead(0, b);
		check("tick count", b - a, 64'h3);
	endtask : t_run
	task automatic t_stop();
		g_core[0].i_core.setStop(1'b1);
		check("stopped", stopped, 1'b1);
		check("hold", cntHold[0], 1'b1);
		cntReq[0] = 1'b1;
		repeat (5) begin
			@(negedge clk_sys);
			check("held ack", cntAck[0], 1'b0);
		end
		pipeSync[0] = 1'b1;
		@(negedge clk_sys);
		pipeSync[0] = 1'b0;
		cntRead(0, a);
		repeat (3 * TD) @(negedge clk_sys);
		cntRead(1, b);
		check("frozen other core", b, a);
		cntRead(0, b);
		check("frozen", b, a);
		cntWr[1] = 1'b1;
		cntWd[1] = 64'h100;
		cntRead(1, b);
		check("write returns old", b, a);
		cntWr[1] = 1'b0;
		@(negedge clk_sys);
		cntRead(1, b);
		check("write kept", b, 64'h100);
	endtask : t_stop
	task automatic t_compare();
		mask[0] = 1'b0;
		cmp[0] = a + 64'h5;
		repeat (4) @(negedge clk_sys);
		check("no post", matchFlag[0], 1'b0);
		cmp[0] = a;
		repeat (3) @(negedge clk_sys);
		check("match flag", matchFlag[0], 1'b1);
		check("level 14", irq[0], 1'b1);
		check("no wake", wake[0], 1'b0);
		clr[0] = 1'b1;
		@(negedge clk_sys);
		clr[0] = 1'b0;
		check("set wins", matchFlag[0], 1'b1);
		prio[0] = strc_pkg::IRQ_LEVEL;
		repeat (2) @(negedge clk_sys);
		check("level not below", irq[0], 1'b0);
		mask[0] = 1'b1;
		clr[0] = 1'b1;
		@(negedge clk_sys);
		clr[0] = 1'b0;
		@(negedge clk_sys);
		check("cleared", matchFlag[0], 1'b0);
		// Leave a standing match so the restart can be seen to wake core 0
		mask[0] = 1'b0;
		prio[0] = 4'hD;
		@(negedge clk_sys);
	endtask : t_compare
	task automatic t_race();
		fork
			g_core[0].i_core.access(1'b1, 8'h4B, 64'h0, q);
			g_core[1].i_core.access(1'b1, 8'h4B, 64'h1, q);
		join
		// Round robin favours core 1 here, so core 0's run request lands last
		for (int n = 0; n < 8 && wake[0] !== 1'b1; n++) @(negedge clk_sys);
		check("wake running", wake[0], 1'b1);
		repeat (6) @(negedge clk_sys);
		g_core[0].i_core.access(1'b0, 8'h4B, 64'h0, q);
		check("serialised", q, 64'h0);
		check("last write wins", {63'h0, stopped}, 64'h0);
		check("both held", {62'h0, cntHold}, 64'h3);
	endtask : t_race
	// Tests take well under two hundred cycles; this ceiling only catches a hang
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			test_done();
		end
	end
	initial begin
		repeat (20) @(negedge clk_sys);
		reset_n = 1'b1;
		@(negedge clk_sys);
		t_config();
		t_run();
		t_stop();
		t_compare();
		t_race();
		test_done();
	end
endmodule : system_tick_run_control_bench
`default_nettype wire
